// ### gsc_consts.svh
`ifndef GSC_CONSTS_SVH
`define GSC_CONSTS_SVH

// Register byte addresses on the serial port
`define GSC_ADDR_PIN_FUNC 8'h05
`define GSC_ADDR_PIN_DIR 8'h07
`define GSC_ADDR_DRIVE_TYPE 8'h09
`define GSC_ADDR_OUT_LEVEL 8'h0b
`define GSC_ADDR_IN_LEVEL 8'h0d
`define GSC_ADDR_SCAN_CTRL 8'h10
`define GSC_ADDR_MANUAL_CH 8'h11
`define GSC_ADDR_SCAN_MASK 8'h12

// Common reset value of every register
`define GSC_RESET_BYTE 8'h00

// Serial frame opcodes
`define GSC_OP_READ 8'h10
`define GSC_OP_WRITE 8'h08

// Serial frame bit counts: opcode, address, data bytes
`define GSC_BITS_OPCODE 5'h08
`define GSC_BITS_ADDR 5'h10
`define GSC_BITS_FRAME 5'h18

// Scan control field positions
`define GSC_SCAN_RUN_POS 4
`define GSC_SCAN_MODE_HI 1
`define GSC_SCAN_MODE_LO 0
`define GSC_SCAN_CTRL_MASK 8'h13

// Manual channel field: bit 3 marks a reserved code
`define GSC_MANUAL_MASK 8'h0f
`define GSC_MANUAL_RSVD_POS 3

`endif

// ### gsc_pkg.sv
package gsc_pkg;

  // Scan mode encodings
  typedef enum logic [1:0] {
    GSC_MODE_MANUAL = 2'h0,
    GSC_MODE_AUTO = 2'h1,
    GSC_MODE_FLY = 2'h2,
    GSC_MODE_RSVD = 2'h3
  } gsc_mode_t;

  // Serial frame phase
  typedef enum logic {
    GSC_SPI_IDLE,
    GSC_SPI_SHIFT
  } gsc_spi_state_t;

  // Drive of the eight channel pads
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gsc_pad_drive_t;

  // Configuration registers held by the bank
  typedef struct packed {
    logic [7:0] pin_func;
    logic [7:0] pin_dir;
    logic [7:0] drive_type;
    logic [7:0] out_level;
    logic [7:0] scan_ctrl;
    logic [7:0] manual_ch;
    logic [7:0] scan_mask;
  } gsc_cfg_t;

endpackage : gsc_pkg

// ### gsc_regs.sv
`timescale 1ns/1ns
`include "gsc_consts.svh"
module gsc_regs
  import gsc_pkg::*;
(
  input wire logic clk_sys, // 125 MHz system clock
  input wire logic rst_b, // Async reset, active low
  input wire logic spi_cs_b, // Serial chip select, active low
  input wire logic spi_sclk, // Serial clock pin, mode 0
  input wire logic spi_mosi, // Serial data from host
  output logic spi_miso, // Serial data to host
  input wire logic [7:0] pad_in, // Channel pad levels
  output logic [7:0] pad_out, // Channel pad output values
  output logic [7:0] pad_oe, // Channel pad output enables
  input wire logic conv_done, // Conversion finished pulse
  output logic [2:0] scan_channel, // Channel for next conversion
  output logic scan_channel_valid, // Channel selection usable
  output gsc_mode_t scan_mode // Selected scan mode
);

  // Reset release chain
  logic [1:0] rst_sync; // Release flops
  logic rst_b_sys; // Synchronised reset, active low

  // Pin synchronisers: first stage read only by second
  logic [2:0] spi_s1; // cs, sclk, mosi stage 1
  logic [2:0] spi_s2; // Stage 2
  logic sclk_s3; // Old sclk for edge detect
  logic [7:0] pad_s1; // Pad stage 1
  logic [7:0] pad_s2; // Pad stage 2

  // Serial engine state
  gsc_spi_state_t spi_state, next_spi_state; // Frame phase
  logic [4:0] bit_cnt, next_bit_cnt; // Bits taken in frame
  logic [23:0] rx_shift, next_rx_shift; // Opcode, address and data so far
  logic [7:0] tx_shift, next_tx_shift; // Read data out
  logic next_spi_miso; // Next serial out bit

  // Register bank and sequencer
  gsc_cfg_t cfg, next_cfg; // Configuration registers
  logic [2:0] cur_ch, next_cur_ch; // Active channel
  logic run_q, next_run_q; // Auto mode with run seen last cycle

  // Edge and field helpers
  logic cs_act; // Select asserted
  logic sclk_rise; // Rising serial clock
  logic sclk_fall; // Falling serial clock
  logic [7:0] gpio_in_mask; // Channels acting as digital inputs
  logic [7:0] gpio_out_mask; // Channels acting as digital outputs
  logic scan_run; // Run bit
  logic auto_running; // Auto mode with run set
  logic [7:0] rx_byte; // Byte completed on this edge

  // Read mux; unmapped addresses and reserved bits give zero
  function automatic logic [7:0] reg_read(input logic [7:0] addr, input gsc_cfg_t c,
                                          input logic [7:0] gin);
    case (addr)
      `GSC_ADDR_PIN_FUNC: reg_read = c.pin_func;
      `GSC_ADDR_PIN_DIR: reg_read = c.pin_dir;
      `GSC_ADDR_DRIVE_TYPE: reg_read = c.drive_type;
      `GSC_ADDR_OUT_LEVEL: reg_read = c.out_level;
      `GSC_ADDR_IN_LEVEL: reg_read = gin;
      `GSC_ADDR_SCAN_CTRL: reg_read = c.scan_ctrl & `GSC_SCAN_CTRL_MASK;
      `GSC_ADDR_MANUAL_CH: reg_read = c.manual_ch & `GSC_MANUAL_MASK;
      `GSC_ADDR_SCAN_MASK: reg_read = c.scan_mask;
      default: reg_read = `GSC_RESET_BYTE;
    endcase
  endfunction : reg_read

  // Next enabled channel strictly after 'from', wrapping upward
  function automatic logic [2:0] next_enabled(input logic [7:0] mask, input logic [2:0] from);
    logic [2:0] idx;
    next_enabled = from;
    for (int i = 8; i >= 1; i--) begin
      idx = from + 3'(i);
      if (mask[idx]) begin
        next_enabled = idx;
      end
    end
  endfunction : next_enabled

  // Reset release: assert at once, release after two edges
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_b_sys = rst_sync[1];

  // Input synchronisers
  always_ff @(posedge clk_sys or negedge rst_b_sys) begin
    if (!rst_b_sys) begin
      spi_s1 <= 3'h1;
      spi_s2 <= 3'h1;
      sclk_s3 <= 1'b0;
      pad_s1 <= `GSC_RESET_BYTE;
      pad_s2 <= `GSC_RESET_BYTE;
    end else begin
      spi_s1 <= {spi_mosi, spi_sclk, spi_cs_b};
      spi_s2 <= spi_s1;
      sclk_s3 <= spi_s2[1];
      pad_s1 <= pad_in;
      pad_s2 <= pad_s1;
    end
  end

  // Pin role decode
  always_comb begin
    cs_act = !spi_s2[0];
    sclk_rise = spi_s2[1] && !sclk_s3;
    sclk_fall = !spi_s2[1] && sclk_s3;
    gpio_out_mask = cfg.pin_func & cfg.pin_dir;
    gpio_in_mask = cfg.pin_func & ~cfg.pin_dir;
    scan_run = cfg.scan_ctrl[`GSC_SCAN_RUN_POS];
    scan_mode = gsc_mode_t'(cfg.scan_ctrl[`GSC_SCAN_MODE_HI:`GSC_SCAN_MODE_LO]);
    auto_running = (scan_mode == GSC_MODE_AUTO) && scan_run;
    rx_byte = {rx_shift[6:0], spi_s2[2]};
  end

  // Serial frame engine and register writes
  always_comb begin
    next_spi_state = spi_state;
    next_bit_cnt = bit_cnt;
    next_rx_shift = rx_shift;
    next_tx_shift = tx_shift;
    next_spi_miso = spi_miso;
    next_cfg = cfg;
    case (spi_state)
      GSC_SPI_IDLE: begin
        next_bit_cnt = 5'h00;
        next_spi_miso = 1'b0;
        if (cs_act) begin
          next_spi_state = GSC_SPI_SHIFT;
        end
      end
      GSC_SPI_SHIFT: begin
        if (!cs_act) begin
          // Short frames are dropped without side effect
          next_spi_state = GSC_SPI_IDLE;
        end else if (sclk_rise && bit_cnt != `GSC_BITS_FRAME) begin
          // Full frame kept so opcode and address survive the data byte
          next_rx_shift = {rx_shift[22:0], spi_s2[2]};
          next_bit_cnt = bit_cnt + 5'h01;
          if (bit_cnt + 5'h01 == `GSC_BITS_ADDR && rx_shift[14:7] == `GSC_OP_READ) begin
            // Read data loaded once the address is in
            next_tx_shift = reg_read(rx_byte, cfg, pad_s2 & gpio_in_mask);
          end
          if (bit_cnt + 5'h01 == `GSC_BITS_FRAME && rx_shift[22:15] == `GSC_OP_WRITE) begin
            case (rx_shift[14:7])
              `GSC_ADDR_PIN_FUNC: next_cfg.pin_func = rx_byte;
              `GSC_ADDR_PIN_DIR: next_cfg.pin_dir = rx_byte;
              `GSC_ADDR_DRIVE_TYPE: next_cfg.drive_type = rx_byte;
              `GSC_ADDR_OUT_LEVEL: next_cfg.out_level = rx_byte;
              `GSC_ADDR_SCAN_CTRL: next_cfg.scan_ctrl = rx_byte & `GSC_SCAN_CTRL_MASK;
              `GSC_ADDR_MANUAL_CH: next_cfg.manual_ch = rx_byte & `GSC_MANUAL_MASK;
              `GSC_ADDR_SCAN_MASK: next_cfg.scan_mask = rx_byte;
              default: next_cfg = cfg; // Read-only and unmapped ignored
            endcase
          end
        end else if (sclk_fall && bit_cnt >= `GSC_BITS_ADDR && bit_cnt < `GSC_BITS_FRAME) begin
          // Mode 0: change output on falling edge
          next_spi_miso = tx_shift[7];
          next_tx_shift = {tx_shift[6:0], 1'b0};
        end
      end
      default: next_spi_state = GSC_SPI_IDLE;
    endcase
  end

  // Serial and register state
  always_ff @(posedge clk_sys or negedge rst_b_sys) begin
    if (!rst_b_sys) begin
      spi_state <= GSC_SPI_IDLE;
      bit_cnt <= 5'h00;
      rx_shift <= 24'h000000;
      tx_shift <= `GSC_RESET_BYTE;
      spi_miso <= 1'b0;
      cfg <= '0;
    end else begin
      spi_state <= next_spi_state;
      bit_cnt <= next_bit_cnt;
      rx_shift <= next_rx_shift;
      tx_shift <= next_tx_shift;
      spi_miso <= next_spi_miso;
      cfg <= next_cfg;
    end
  end

  // Channel sequencer; conversion engine advances it
  always_comb begin
    next_cur_ch = cur_ch;
    next_run_q = auto_running;
    scan_channel_valid = 1'b0;
    case (scan_mode)
      GSC_MODE_MANUAL: begin
        next_cur_ch = cfg.manual_ch[2:0];
        scan_channel_valid = !cfg.manual_ch[`GSC_MANUAL_RSVD_POS];
      end
      GSC_MODE_AUTO: begin
        scan_channel_valid = auto_running && (cfg.scan_mask != 8'h00);
        if (auto_running && !run_q) begin
          // Start from the lowest enabled channel
          next_cur_ch = next_enabled(cfg.scan_mask, 3'h7);
        end else if (auto_running && conv_done) begin
          next_cur_ch = next_enabled(cfg.scan_mask, cur_ch);
        end
      end
      default: begin
        // On-the-fly and reserved modes hold the channel
        next_cur_ch = cur_ch;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk_sys or negedge rst_b_sys) begin
    if (!rst_b_sys) begin
      cur_ch <= 3'h0;
      run_q <= 1'b0;
    end else begin
      cur_ch <= next_cur_ch;
      run_q <= next_run_q;
    end
  end
  assign scan_channel = cur_ch;

  // Pad drivers; open-drain only ever pulls low
  gsc_pad_drive_t pad_drv; // Combined pad drive
  always_comb begin
    pad_drv.out = cfg.out_level & cfg.drive_type;
    pad_drv.oe = gpio_out_mask & (cfg.drive_type | ~cfg.out_level);
  end
  assign pad_out = pad_drv.out;
  assign pad_oe = pad_drv.oe;

endmodule : gsc_regs

// ### gsc_regs_chk.sv
`timescale 1ns/1ns
module gsc_regs_chk
  import gsc_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic spi_cs_b, // Serial select
  input wire logic conv_done, // Conversion pulse
  input wire logic [7:0] pad_out, // Pad values
  input wire logic [7:0] pad_oe, // Pad enables
  input wire logic [2:0] scan_channel, // Active channel
  input wire logic scan_channel_valid, // Channel usable
  input wire gsc_mode_t scan_mode // Scan mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Select idle long enough that no write can still be landing
  sequence quiet_s;
    spi_cs_b [*4];
  endsequence
  // Reset checks must run while reset is low, so no disable there
  a_rst_pads: assert property (disable iff (1'b0) !rst_b |-> pad_oe == 8'h00)
    else $error("pads driven in reset");
  a_rst_chan: assert property (disable iff (1'b0) !rst_b |-> scan_channel == 3'h0)
    else $error("channel not zero in reset");
  a_rst_release: assert property (disable iff (1'b0)
    $rose(rst_b) |-> (scan_mode == GSC_MODE_MANUAL && scan_channel_valid) [*2])
    else $error("mode not manual after reset");
  a_pads_hold: assert property (quiet_s |=> $stable(pad_out) && $stable(pad_oe))
    else $error("pads moved with no write");
  a_mode_hold: assert property (quiet_s |=> $stable(scan_mode))
    else $error("mode moved with no write");
  a_manual_hold: assert property (quiet_s ##0 scan_mode == GSC_MODE_MANUAL |=>
    $stable(scan_channel) && $stable(scan_channel_valid))
    else $error("manual channel moved");
  a_fly_hold: assert property (quiet_s ##0 scan_mode[1] |=> $stable(scan_channel))
    else $error("channel moved outside auto");
  a_step_cause: assert property (quiet_s ##0 scan_mode == GSC_MODE_AUTO && !conv_done
    |=> $stable(scan_channel))
    else $error("auto step with no conversion");
  c_auto_step: cover property (scan_mode == GSC_MODE_AUTO && conv_done);
  c_frame_end: cover property (!spi_cs_b ##1 spi_cs_b);
  c_reset_out: cover property (disable iff (1'b0) $rose(rst_b));
endmodule : gsc_regs_chk

bind gsc_regs gsc_regs_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .spi_cs_b(spi_cs_b),
  .conv_done(conv_done), .pad_out(pad_out), .pad_oe(pad_oe), .scan_channel(scan_channel),
  .scan_channel_valid(scan_channel_valid), .scan_mode(scan_mode));

// ### gsc_host.sv
`timescale 1ns/1ns
module gsc_host (
  output logic spi_cs_b, // Select, active low
  output logic spi_sclk, // Serial clock, idle low
  output logic spi_mosi, // Data to device
  input wire logic spi_miso, // Data from device
  input wire logic clk_sys // System clock
);
  initial begin
    spi_cs_b = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end
  // One 24-bit frame, MSB first; four-cycle phases so synced edges stay apart
  task automatic xfer(input logic [7:0] op, input logic [7:0] adr,
    input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] sh;
    sh = {op, adr, wd};
    rd = 8'h00;
    @(negedge clk_sys);
    spi_cs_b = 1'b0;
    for (int i = 0; i < 24; i++) begin
      spi_mosi = sh[23 - i];
      repeat (4) @(negedge clk_sys);
      spi_sclk = 1'b1;
      rd = {rd[6:0], spi_miso}; // Last eight samples are the data byte
      repeat (4) @(negedge clk_sys);
      spi_sclk = 1'b0;
    end
    repeat (6) @(negedge clk_sys);
    spi_cs_b = 1'b1;
    spi_mosi = ~spi_mosi; // Released line shows no stale bit
    repeat (4) @(negedge clk_sys);
  endtask : xfer
endmodule : gsc_host

// ### gpio_and_scan_config_regs_tb.sv
`timescale 1ns/1ns
`include "gsc_consts.svh"
module gpio_and_scan_config_regs_tb
  import gsc_pkg::*;
;
  logic clk_sys = 1'b0; // 125 MHz
  logic rst_b = 1'b1; // Reset, active low; pulled low just after start
  logic conv_done = 1'b0; // Conversion pulse
  logic [7:0] ext_lvl = 8'h5a; // Outside source on undriven pads
  logic spi_cs_b, spi_sclk, spi_mosi, spi_miso;
  logic [7:0] pad_in, pad_out, pad_oe, rd;
  logic [2:0] scan_channel;
  logic scan_channel_valid;
  gsc_mode_t scan_mode;
  int n_errors = 0;
  int checks = 0;
  logic [7:0] addrs [7] = '{8'h09, 8'h0b, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h1f};
  always #4 clk_sys = ~clk_sys;
  // Enabled drivers win the wire, otherwise the outside source
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
  gsc_regs DUT (.clk_sys(clk_sys), .rst_b(rst_b), .spi_cs_b(spi_cs_b), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .conv_done(conv_done), .scan_channel(scan_channel),
    .scan_channel_valid(scan_channel_valid), .scan_mode(scan_mode));
  gsc_host host (.clk_sys(clk_sys), .spi_cs_b(spi_cs_b), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(`GSC_OP_WRITE, a, d, rd);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.xfer(`GSC_OP_READ, a, 8'h00, rd);
    chk(rd, e);
  endtask : rdc
  // One-cycle conversion pulse, then let the step land
  task automatic pulse;
    conv_done = 1'b1;
    @(negedge clk_sys);
    conv_done = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : pulse
  task automatic give_verdict;
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    // A real falling edge, so the asynchronous clear acts before the first clock
    #1;
    rst_b = 1'b0;
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    foreach (addrs[i]) rdc(addrs[i], 8'h00);
    // Channels 2,3 analog; 0,1 outputs; 4-7 inputs
    wr(`GSC_ADDR_PIN_FUNC, 8'hf3);
    wr(`GSC_ADDR_PIN_DIR, 8'h0f);
    wr(`GSC_ADDR_DRIVE_TYPE, 8'h01);
    wr(`GSC_ADDR_OUT_LEVEL, 8'h03);
    chk(pad_oe, 8'h01);
    chk(pad_out, 8'h01);
    wr(`GSC_ADDR_OUT_LEVEL, 8'h00);
    chk(pad_oe, 8'h03);
    rdc(`GSC_ADDR_DRIVE_TYPE, 8'h01);
    rdc(`GSC_ADDR_OUT_LEVEL, 8'h00);
    wr(`GSC_ADDR_IN_LEVEL, 8'hff);
    rdc(`GSC_ADDR_IN_LEVEL, 8'h50);
    wr(`GSC_ADDR_SCAN_CTRL, 8'hff);
    rdc(`GSC_ADDR_SCAN_CTRL, 8'h13);
    wr(`GSC_ADDR_MANUAL_CH, 8'hff);
    rdc(`GSC_ADDR_MANUAL_CH, 8'h0f);
    for (int m = 0; m < 4; m++) begin
      wr(`GSC_ADDR_SCAN_CTRL, 8'(m));
      chk({6'h00, scan_mode}, 8'(m));
    end
    wr(`GSC_ADDR_SCAN_CTRL, 8'h00);
    chk({4'h0, scan_channel_valid, scan_channel}, 8'h07);
    wr(`GSC_ADDR_MANUAL_CH, 8'h02);
    chk({4'h0, scan_channel_valid, scan_channel}, 8'h0a);
    wr(`GSC_ADDR_SCAN_MASK, 8'h0a);
    wr(`GSC_ADDR_SCAN_CTRL, 8'h11);
    chk({4'h0, scan_channel_valid, scan_channel}, 8'h09);
    pulse();
    chk({4'h0, scan_channel_valid, scan_channel}, 8'h0b);
    pulse();
    chk({4'h0, scan_channel_valid, scan_channel}, 8'h09);
    wr(`GSC_ADDR_SCAN_CTRL, 8'h01);
    pulse();
    chk({5'h00, scan_channel}, 8'h01);
    wr(`GSC_ADDR_SCAN_CTRL, 8'h12);
    pulse();
    chk({5'h00, scan_channel}, 8'h01);
    rst_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    rdc(`GSC_ADDR_SCAN_CTRL, 8'h00);
    give_verdict();
  end
  // Run needs about 50 us; cut a hang well past that
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule : gpio_and_scan_config_regs_tb
